// ===== design/dcrb_consts.vh
// Register numbers, field positions and reset values of the drive register bank.
// Assumes the includer reaches registers by 16-bit register number.
`ifndef DCRB_CONSTS_VH
`define DCRB_CONSTS_VH

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define DCRB_REG_CONTACT 16'h0009
`define DCRB_REG_REFSEL 16'h000f
`define DCRB_REG_RUNSTAT 16'h0010
`define DCRB_REG_KEYPAD 16'h0011
`define DCRB_REG_SETERR 16'h0012
`define DCRB_REG_FAULT1 16'h0014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCRB_CON_RELAY1 0
`define DCRB_CON_RELAY2 1
`define DCRB_CON_FLT_OWN 6
`define DCRB_CON_FLT_VAL 7
`define DCRB_REF_TARGET 1
`define DCRB_REF_DI5 12
`define DCRB_REF_DI6 13
`define DCRB_REF_DI7 14

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define DCRB_CONTACT_RST 16'h0000
`define DCRB_REFSEL_RST 16'h0000
`define DCRB_CONTACT_MASK 16'h00c3
`define DCRB_REFSEL_MASK 16'h7002

`endif

// ===== design/dcrb_reg_bank.v
// Drive communication register bank: two writable reference words and four monitor words.
// Assumes a message decoder outside issues single-cycle register reads and writes.
`timescale 1ns/1ps
`include "dcrb_consts.vh"

module dcrb_reg_bank (
   input wire i_clk,
   input wire i_resetn,
   input wire i_ce,
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [15:0] i_addr,
   input wire [15:0] i_wdata,
   output reg [15:0] o_rdata_ff,
   output reg o_rvalid_ff,
   output reg o_rerr_ff,
   output reg o_werr_ff,
   input wire [7:0] i_run_status,
   input wire i_setting_error_alarm,
   input wire i_fault_active,
   input wire i_prog_mode,
   input wire [1:0] i_keypad_type,
   input wire [15:0] i_setting_error_number,
   input wire i_bus_fuse_blown,
   input wire i_undervoltage_main,
   input wire i_undervoltage_control,
   input wire i_undervoltage_charge,
   input wire i_ground_fault_flag,
   input wire i_overcurrent_flag,
   input wire i_bus_overvoltage_flag,
   input wire i_heatsink_prealarm_flag,
   input wire i_heatsink_overheat_flag,
   input wire i_motor_overload_flag,
   input wire i_drive_overload_flag,
   input wire i_overtorque_flag,
   input wire i_fault_relay_local,
   output wire o_relay_out_first,
   output wire o_relay_out_second,
   output wire o_fault_relay_out,
   output wire o_target_from_comm,
   output wire o_digital_input_five_bcast,
   output wire o_digital_input_six_bcast,
   output wire o_digital_input_seven_bcast,
   output wire [15:0] o_contact_output_control,
   output wire [15:0] o_reference_source_select
);

   // ----------------------------------------
   // Storage and next-state nets
   // ----------------------------------------
   reg [15:0] contact_ff;
   reg [15:0] refsel_ff;
   reg [15:0] nxt_contact;
   reg [15:0] nxt_refsel;
   reg nxt_werr;
   reg [15:0] nxt_rdata;
   reg nxt_rerr;
   reg fault_relay_sel;
   wire [15:0] contact_mask;
   wire [15:0] refsel_mask;
   wire [15:0] contact_wdata;
   wire [15:0] refsel_wdata;
   wire [15:0] run_word;
   wire [15:0] key_word;
   wire [15:0] fault_word;

   assign contact_mask = `DCRB_CONTACT_MASK;
   assign refsel_mask = `DCRB_REFSEL_MASK;

   // ----------------------------------------
   // Write data masking
   // ----------------------------------------
   // Unused bits are forced low so a careless master cannot set them
   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < 16; bit_idx = bit_idx + 1) begin : g_wmask
         assign contact_wdata[bit_idx] = i_wdata[bit_idx] & contact_mask[bit_idx];
         assign refsel_wdata[bit_idx] = i_wdata[bit_idx] & refsel_mask[bit_idx];
      end
   endgenerate

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   always @* begin
      nxt_contact = contact_ff;
      nxt_refsel = refsel_ff;
      nxt_werr = 1'b0;
      if (i_wr_en) begin
         if (i_addr == `DCRB_REG_CONTACT) begin
            nxt_contact = contact_wdata;
         end else if (i_addr == `DCRB_REG_REFSEL) begin
            nxt_refsel = refsel_wdata;
         end else begin
            // Monitor and reserved words never change on write
            nxt_werr = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Reference word registers
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         contact_ff <= `DCRB_CONTACT_RST;
         refsel_ff <= `DCRB_REFSEL_RST;
         o_werr_ff <= 1'b0;
      end else if (i_ce) begin
         contact_ff <= nxt_contact;
         refsel_ff <= nxt_refsel;
         o_werr_ff <= nxt_werr;
      end
   end

   // ----------------------------------------
   // Outputs steered by the reference words
   // ----------------------------------------
   assign o_relay_out_first = contact_ff[`DCRB_CON_RELAY1];
   assign o_relay_out_second = contact_ff[`DCRB_CON_RELAY2];
   assign o_target_from_comm = refsel_ff[`DCRB_REF_TARGET];
   assign o_digital_input_five_bcast = refsel_ff[`DCRB_REF_DI5];
   assign o_digital_input_six_bcast = refsel_ff[`DCRB_REF_DI6];
   assign o_digital_input_seven_bcast = refsel_ff[`DCRB_REF_DI7];
   assign o_contact_output_control = contact_ff;
   assign o_reference_source_select = refsel_ff;

   // ----------------------------------------
   // Fault relay ownership
   // ----------------------------------------
   // Combinational so the local fault path reaches the relay with no cycle of lag
   always @* begin
      if (contact_ff[`DCRB_CON_FLT_OWN]) begin
         fault_relay_sel = contact_ff[`DCRB_CON_FLT_VAL];
      end else begin
         fault_relay_sel = i_fault_relay_local;
      end
   end

   assign o_fault_relay_out = fault_relay_sel;

   // ----------------------------------------
   // Monitor words
   // ----------------------------------------
   assign run_word[7:0] = i_run_status;
   assign run_word[15:8] = 8'h00;

   assign key_word[0] = i_setting_error_alarm;
   assign key_word[1] = i_fault_active;
   assign key_word[2] = i_prog_mode;
   assign key_word[4:3] = i_keypad_type;
   assign key_word[15:5] = 11'h000;

   assign fault_word[0] = i_bus_fuse_blown;
   assign fault_word[1] = i_undervoltage_main;
   assign fault_word[2] = i_undervoltage_control;
   assign fault_word[3] = i_undervoltage_charge;
   assign fault_word[4] = 1'b0;
   assign fault_word[5] = i_ground_fault_flag;
   assign fault_word[6] = i_overcurrent_flag;
   assign fault_word[7] = i_bus_overvoltage_flag;
   assign fault_word[8] = i_heatsink_prealarm_flag;
   assign fault_word[9] = i_heatsink_overheat_flag;
   assign fault_word[10] = i_motor_overload_flag;
   assign fault_word[11] = i_drive_overload_flag;
   assign fault_word[12] = i_overtorque_flag;
   assign fault_word[13] = 1'b0;
   assign fault_word[14] = 1'b0;
   assign fault_word[15] = 1'b0;

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   always @* begin
      nxt_rdata = 16'h0000;
      nxt_rerr = 1'b0;
      if (i_addr == `DCRB_REG_CONTACT) begin
         nxt_rdata = contact_ff;
      end else if (i_addr == `DCRB_REG_REFSEL) begin
         nxt_rdata = refsel_ff;
      end else if (i_addr == `DCRB_REG_RUNSTAT) begin
         nxt_rdata = run_word;
      end else if (i_addr == `DCRB_REG_KEYPAD) begin
         nxt_rdata = key_word;
      end else if (i_addr == `DCRB_REG_SETERR) begin
         nxt_rdata = i_setting_error_number;
      end else if (i_addr == `DCRB_REG_FAULT1) begin
         nxt_rdata = fault_word;
      end else begin
         // Reserved numbers read zero and flag the miss
         nxt_rerr = 1'b1;
      end
   end

   // ----------------------------------------
   // Read answer
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_rvalid_ff <= 1'b0;
         o_rerr_ff <= 1'b0;
      end else if (i_ce) begin
         o_rvalid_ff <= i_rd_en;
         o_rerr_ff <= i_rd_en & nxt_rerr;
      end
   end

   // Read data holds between reads so a slow decoder may fetch it late
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_rdata_ff <= 16'h0000;
      end else if (i_ce && i_rd_en) begin
         o_rdata_ff <= nxt_rdata;
      end
   end

endmodule // dcrb_reg_bank

// ===== dv/dcrb_reg_bank_sva.sv
// Port relation checker for the drive register bank.
// Bound to the bank; ports match by name.
`timescale 1ns/1ps
module dcrb_reg_bank_sva (
   input wire i_clk, i_resetn, i_ce, i_rd_en, i_wr_en, i_fault_relay_local,
   input wire [15:0] i_addr, o_rdata_ff, o_contact_output_control, o_reference_source_select,
   input wire [7:0] i_run_status,
   input wire o_rvalid_ff, o_werr_ff, o_relay_out_first, o_relay_out_second,
   input wire o_fault_relay_out, o_target_from_comm, o_digital_input_seven_bcast,
   input wire o_digital_input_five_bcast, o_digital_input_six_bcast
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire [15:0] c = o_contact_output_control;
   wire [15:0] r = o_reference_source_select;
   wire st = i_ce && i_addr == 16'h0010;
   chk_relay_one: assert property (o_relay_out_first == c[0]) else $error("relay");
   chk_relay_two: assert property (o_relay_out_second == c[1]) else $error("relay");
   chk_fault_mux:
      assert property (o_fault_relay_out == (c[6] ? c[7] : i_fault_relay_local)) else $error("mux");
   chk_target_sel: assert property (o_target_from_comm == r[1]) else $error("target");
   chk_input_seven:
      assert property (o_digital_input_seven_bcast == r[14]) else $error("input");
   chk_input_five:
      assert property (o_digital_input_five_bcast == r[12]) else $error("input");
   chk_input_six:
      assert property (o_digital_input_six_bcast == r[13]) else $error("input");
   chk_ce_freeze:
      assert property (!i_ce |=> $stable(c) && $stable(r)) else $error("freeze");
   chk_read_ans: assert property (i_ce && i_rd_en |=> o_rvalid_ff) else $error("rvalid");
   chk_ro_refuse:
      assert property (st && i_wr_en |=> o_werr_ff && $stable(c)) else $error("refuse");
   chk_run_read:
      assert property (st && i_rd_en |=> o_rdata_ff == {8'h00, $past(i_run_status)}) else $error("run");
endmodule // dcrb_reg_bank_sva

// ===== dv/dcrb_master.sv
// Serial master stand-in issuing single-word register requests.
// Assumes the bank takes requests on the rising edge.
`timescale 1ns/1ps
module dcrb_master (
   input wire i_clk,
   output reg o_wr_en = 1'b0,
   output reg o_rd_en = 1'b0,
   output reg [15:0] o_addr = 16'h0,
   output reg [15:0] o_wdata = 16'h0
);
   // Bus scrambled after each request so stale values never look valid
   task req(input w, input [15:0] a, input [15:0] d);
      begin
         @(negedge i_clk);
         {o_wr_en, o_rd_en, o_addr, o_wdata} = {w, !w, a, d};
         @(negedge i_clk);
         {o_wr_en, o_rd_en, o_addr, o_wdata} = {2'b00, ~a, ~d};
      end
   endtask
endmodule // dcrb_master

// ===== dv/tb_drive_comm_register_bank.sv
// Self-checking bench for the drive register bank.
// Assumes the master model and checker compile first.
`timescale 1ns/1ps
module tb_drive_comm_register_bank;
   reg i_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1;
   reg [15:0] p = 16'h0, a, e;
   reg [47:0] rows [0:9] = '{48'h0009_ffff_00c3, 48'h000f_ffff_7002, 48'h0009_00c1_00c1,
      48'h0010_ffff_00ff, 48'h0011_ffff_001f, 48'h0011_0008_0008, 48'h0011_0004_0004,
      48'h0012_1234_1234, 48'h0014_ffff_1fef, 48'h0014_0a51_0a41};
   integer k, tests_run = 0, miscompares = 0;
   wire i_wr_en, i_rd_en, o_rvalid_ff, o_rerr_ff, o_werr_ff, o_fault_relay_out, o_relay_out_first;
   wire o_relay_out_second, o_target_from_comm, o_digital_input_five_bcast;
   wire o_digital_input_six_bcast, o_digital_input_seven_bcast;
   wire [15:0] i_addr, i_wdata, o_rdata_ff, o_contact_output_control, o_reference_source_select;
   always #2.5 i_clk = ~i_clk;
   dcrb_master u_m (.i_clk(i_clk), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
      .o_wdata(i_wdata));
   dcrb_reg_bank uut (.*, .i_run_status(p[7:0]), .i_setting_error_alarm(p[0]),
      .i_fault_active(p[1]), .i_prog_mode(p[2]), .i_keypad_type(p[4:3]),
      .i_setting_error_number(p), .i_bus_fuse_blown(p[0]), .i_undervoltage_main(p[1]),
      .i_undervoltage_control(p[2]), .i_undervoltage_charge(p[3]), .i_ground_fault_flag(p[5]),
      .i_overcurrent_flag(p[6]), .i_bus_overvoltage_flag(p[7]), .i_heatsink_prealarm_flag(p[8]),
      .i_heatsink_overheat_flag(p[9]), .i_motor_overload_flag(p[10]),
      .i_drive_overload_flag(p[11]), .i_overtorque_flag(p[12]), .i_fault_relay_local(p[15]));
   task check(input [17:0] got, input [17:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("Checks %0d, mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      repeat (16) @(negedge i_clk);
      i_resetn = 1'b1;
      check({2'b00, o_contact_output_control | o_reference_source_select}, 18'h0);
      for (k = 0; k < 10; k = k + 1) begin
         {a, p, e} = rows[k];
         if (a < 16'h0010) u_m.req(1'b1, a, p);
         u_m.req(1'b0, a, 16'h0);
         check({2'b00, o_rdata_ff}, {2'b00, e});
      end
      check({12'h0, o_relay_out_first, o_relay_out_second, o_target_from_comm,
         o_digital_input_five_bcast, o_digital_input_six_bcast, o_digital_input_seven_bcast},
         18'h2f);
      p = 16'h0;
      u_m.req(1'b1, 16'h0010, 16'hffff);
      check({1'b0, o_werr_ff, o_contact_output_control}, 18'h100c1);
      u_m.req(1'b0, 16'h0013, 16'h0);
      check({o_rvalid_ff, o_rerr_ff, o_rdata_ff}, 18'h30000);
      u_m.req(1'b1, 16'h0009, 16'h0080);
      p = 16'h8000;
      #1 check({17'h0, o_fault_relay_out}, 18'h1);
      u_m.req(1'b1, 16'h0009, 16'h0040);
      check({17'h0, o_fault_relay_out}, 18'h0);
      i_resetn = 1'b0;
      @(negedge i_clk) i_resetn = 1'b1;
      check({1'b0, o_fault_relay_out, o_contact_output_control}, 18'h10000);
      i_ce = 1'b0;
      u_m.req(1'b1, 16'h0009, 16'h0003);
      check({2'b00, o_contact_output_control}, 18'h0);
      i_ce = 1'b1;
      give_verdict;
   end
endmodule // tb_drive_comm_register_bank
bind dcrb_reg_bank dcrb_reg_bank_sva u_sva (.*);
